// ---- common/sdram_pkg.sv ----
// sdram_pkg: constants, types and helpers for the synchronous dram array
package sdram_pkg;
   localparam int BANKS = 4;
   localparam int ROWS = 2048;
   localparam int COLS = 256;
   localparam int COL_BITS = 8;
   localparam int LANES = 4;
   localparam int MEM_WORDS = BANKS * ROWS * COLS;
   localparam int AUTO_PRE_BIT = 10;
   localparam int MODE_WIDTH = 6;
   localparam int STATUS_WIDTH = 6;
   localparam int REFRESH_WIDTH = 16;
   localparam logic [7:0] MODE_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] REFRESH_OFFSET = 8'h08;
   localparam logic [5:0] MODE_RESET = 6'h02;
   localparam logic [2:0] LEN_CODE_1 = 3'h0;
   localparam logic [2:0] LEN_CODE_2 = 3'h1;
   localparam logic [2:0] LEN_CODE_4 = 3'h2;
   localparam logic [2:0] LEN_CODE_8 = 3'h3;
   localparam logic [2:0] LEN_CODE_PAGE = 3'h7;
   localparam logic [8:0] PAGE_BEATS = 9'h100;

   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } cmd_pins_t;

   typedef struct packed {
      logic single_write;
      logic cas3;
      logic interleave;
      logic [2:0] len_code;
   } mode_t;

   typedef struct packed {
      logic burst_write;
      logic burst_busy;
      logic [3:0] rows_open;
   } status_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_READ = 3'b010,
      ST_WRITE = 3'b100
   } burst_state_t;

   typedef enum logic [2:0] {
      CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_STOP, CMD_PRE, CMD_REFRESH, CMD_LOAD
   } cmd_t;

   function automatic cmd_t decode_cmd(input cmd_pins_t p);
      cmd_t c;
      c = CMD_NOP;
      if (!p.cs_n) begin
         case ({p.ras_n, p.cas_n, p.we_n})
            3'h3: c = CMD_ACT;
            3'h5: c = CMD_READ;
            3'h4: c = CMD_WRITE;
            3'h6: c = CMD_STOP;
            3'h2: c = CMD_PRE;
            3'h1: c = CMD_REFRESH;
            3'h0: c = CMD_LOAD;
            default: c = CMD_NOP;
         endcase
      end
      return c;
   endfunction : decode_cmd

   function automatic logic [8:0] beats_of(input logic [2:0] code);
      case (code)
         LEN_CODE_1: return 9'h001;
         LEN_CODE_2: return 9'h002;
         LEN_CODE_4: return 9'h004;
         LEN_CODE_8: return 9'h008;
         LEN_CODE_PAGE: return PAGE_BEATS;
         default: return 9'h001;
      endcase
   endfunction : beats_of

   function automatic logic [20:0] mem_index(input logic [1:0] bank, input logic [10:0] row,
                                             input logic [7:0] col);
      return {bank, row, col};
   endfunction : mem_index
endpackage : sdram_pkg

// ---- rtl/ahb_mode_regs.sv ----
// ahb_mode_regs: ahb-lite slave holding burst mode and showing array state
module ahb_mode_regs
   import sdram_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic load_mode,
   input wire logic [5:0] load_value,
   input wire status_t status,
   input wire logic [15:0] refresh_count,
   output mode_t mode,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   mode_t mode_reg;
   logic [31:0] hrdata_reg;
   logic hreadyout_reg;
   logic hresp_reg;
   logic take;
   logic [31:0] rd_word;

   assign take = hsel && hready && htrans[1];

   always_comb begin
      rd_word = 32'h0000_0000;
      case (haddr[7:0])
         MODE_OFFSET: rd_word = {{(32-MODE_WIDTH){1'b0}}, mode_reg};
         STATUS_OFFSET: rd_word = {{(32-STATUS_WIDTH){1'b0}}, status};
         REFRESH_OFFSET: rd_word = {{(32-REFRESH_WIDTH){1'b0}}, refresh_count};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata_reg <= 32'h0000_0000;
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end else begin
         wr_pend_reg <= take && hwrite;
         wr_addr_reg <= haddr[7:0];
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
         if (take && !hwrite) begin
            hrdata_reg <= rd_word;
         end
      end
   end

   // mode word: bus write or mode-load command
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mode_reg <= mode_t'(MODE_RESET);
      end else if (load_mode) begin
         mode_reg <= mode_t'(load_value);
      end else if (wr_pend_reg && wr_addr_reg == MODE_OFFSET) begin
         mode_reg <= mode_t'(hwdata[MODE_WIDTH-1:0]);
      end
   end

   assign mode = mode_reg;
   assign hrdata = hrdata_reg;
   assign hreadyout = hreadyout_reg;
   assign hresp = hresp_reg;
endmodule : ahb_mode_regs

// ---- rtl/burst_col_gen.sv ----
// burst_col_gen: column address of one beat within a burst
module burst_col_gen (
   input wire logic [7:0] start_col,
   input wire logic [7:0] beat,
   input wire logic [8:0] len,
   input wire logic interleave,
   output logic [7:0] col
);
   logic [7:0] mask;
   logic [7:0] walk;

   assign mask = 8'(len - 9'h001);
   assign walk = interleave ? (start_col ^ beat) : 8'(start_col + beat);
   assign col = (start_col & ~mask) | (walk & mask);
endmodule : burst_col_gen

// ---- rtl/sdram_core.sv ----
// sdram_core: four-bank synchronous dram array with command decode and bursts
module sdram_core
   import sdram_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cke,
   input wire cmd_pins_t cmd_pins,
   input wire logic [1:0] bank_select_bits,
   input wire logic [10:0] address_bits,
   input wire logic [3:0] byte_lane_masks,
   input wire logic [31:0] data_bus_in,
   output logic [31:0] data_bus_out,
   output logic [31:0] data_bus_oe,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);
   logic [31:0] mem [0:MEM_WORDS-1];
   logic cke_reg;
   logic [3:0] row_open_reg;
   logic [10:0] open_row_reg [0:BANKS-1];
   burst_state_t state_reg;
   logic [1:0] burst_bank_reg;
   logic [10:0] burst_row_reg;
   logic [7:0] burst_start_reg;
   logic [8:0] burst_beat_reg;
   logic [8:0] burst_len_reg;
   logic burst_auto_reg;
   logic [31:0] rd_s0_reg;
   logic [31:0] rd_s1_reg;
   logic rd_v0_reg;
   logic rd_v1_reg;
   logic data_valid_reg;
   logic [31:0] data_bus_out_reg;
   logic [31:0] data_bus_oe_reg;
   logic [15:0] refresh_count_reg;
   mode_t mode;
   status_t status;
   cmd_t cmd;
   logic edge_ok;
   logic bank_ok;
   logic rd_acc;
   logic wr_acc;
   logic go_new;
   logic go_on;
   logic stop_now;
   logic burst_last;
   logic beat_do;
   logic beat_read;
   logic auto_close;
   logic out_valid_next;
   logic precharge_scope_bit;
   logic [7:0] column_address_bits;
   logic [7:0] seq_col;
   logic [7:0] beat_col;
   logic [1:0] beat_bank;
   logic [10:0] beat_row;
   logic [8:0] new_len;
   logic [20:0] beat_index;

   // clock enable sampled at one edge governs the next
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cke_reg <= 1'b1;
      end else begin
         cke_reg <= cke;
      end
   end

   assign edge_ok = cke_reg;
   assign cmd = edge_ok ? decode_cmd(cmd_pins) : CMD_NOP;
   assign column_address_bits = address_bits[COL_BITS-1:0];
   assign precharge_scope_bit = address_bits[AUTO_PRE_BIT];

   // column commands only reach an open bank
   assign bank_ok = row_open_reg[bank_select_bits];
   assign rd_acc = (cmd == CMD_READ) && bank_ok;
   assign wr_acc = (cmd == CMD_WRITE) && bank_ok;
   assign go_new = rd_acc || wr_acc;
   assign new_len = (wr_acc && mode.single_write) ? 9'h001 : beats_of(mode.len_code);

   // stop, or precharge of the bursting bank, ends the burst
   assign stop_now = (cmd == CMD_STOP) ||
      ((cmd == CMD_PRE) && (precharge_scope_bit || bank_select_bits == burst_bank_reg));
   assign go_on = (state_reg != ST_IDLE) && edge_ok && !stop_now && !go_new;
   assign burst_last = (burst_beat_reg + 9'h001 == burst_len_reg) && (burst_len_reg != PAGE_BEATS);

   // one beat per valid edge: new command beat or continuing beat
   assign beat_do = go_new || go_on;
   assign beat_read = go_new ? rd_acc : (state_reg == ST_READ);
   assign beat_bank = go_new ? bank_select_bits : burst_bank_reg;
   assign beat_row = go_new ? open_row_reg[bank_select_bits] : burst_row_reg;
   assign beat_col = go_new ? column_address_bits : seq_col;
   assign beat_index = mem_index(beat_bank, beat_row, beat_col);

   burst_col_gen u_col (
      .start_col(burst_start_reg),
      .beat(burst_beat_reg[7:0]),
      .len(burst_len_reg),
      .interleave(mode.interleave),
      .col(seq_col)
   );

   assign auto_close = (go_new && new_len == 9'h001 && precharge_scope_bit) ||
      (go_on && burst_last && burst_auto_reg);

   // burst sequencer
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         burst_bank_reg <= 2'h0;
         burst_row_reg <= 11'h000;
         burst_start_reg <= 8'h00;
         burst_beat_reg <= 9'h000;
         burst_len_reg <= 9'h001;
         burst_auto_reg <= 1'b0;
      end else if (go_new) begin
         burst_bank_reg <= bank_select_bits;
         burst_row_reg <= open_row_reg[bank_select_bits];
         burst_start_reg <= column_address_bits;
         burst_beat_reg <= 9'h001;
         burst_len_reg <= new_len;
         burst_auto_reg <= precharge_scope_bit;
         if (new_len == 9'h001) begin
            state_reg <= ST_IDLE;
         end else if (rd_acc) begin
            state_reg <= ST_READ;
         end else begin
            state_reg <= ST_WRITE;
         end
      end else if (go_on) begin
         burst_beat_reg <= burst_beat_reg + 9'h001;
         case (state_reg)
            ST_READ, ST_WRITE: begin
               if (burst_last) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end else if (edge_ok && stop_now) begin
         state_reg <= ST_IDLE;
      end
   end

   // bank row table
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         row_open_reg <= 4'h0;
         for (int b = 0; b < BANKS; b++) begin
            open_row_reg[b] <= 11'h000;
         end
      end else begin
         case (cmd)
            CMD_ACT: begin
               row_open_reg[bank_select_bits] <= 1'b1;
               open_row_reg[bank_select_bits] <= address_bits;
            end
            CMD_PRE: begin
               if (precharge_scope_bit) begin
                  row_open_reg <= 4'h0;
               end else begin
                  row_open_reg[bank_select_bits] <= 1'b0;
               end
            end
            default: begin
            end
         endcase
         if (auto_close) begin
            row_open_reg[beat_bank] <= 1'b0;
         end
      end
   end

   // refresh commands counted for software
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         refresh_count_reg <= 16'h0000;
      end else if (cmd == CMD_REFRESH) begin
         refresh_count_reg <= refresh_count_reg + 16'h0001;
      end
   end

   // array write with lane masks
   always_ff @(posedge ref_clk) begin
      if (beat_do && !beat_read) begin
         for (int i = 0; i < LANES; i++) begin
            if (!byte_lane_masks[i]) begin
               mem[beat_index][8*i +: 8] <= data_bus_in[8*i +: 8];
            end
         end
      end
   end

   assign out_valid_next = mode.cas3 ? rd_v1_reg : rd_v0_reg;

   // read pipeline, frozen on a voided edge
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_s0_reg <= 32'h0000_0000;
         rd_s1_reg <= 32'h0000_0000;
         rd_v0_reg <= 1'b0;
         rd_v1_reg <= 1'b0;
         data_valid_reg <= 1'b0;
         data_bus_out_reg <= 32'h0000_0000;
         data_bus_oe_reg <= 32'h0000_0000;
      end else if (edge_ok) begin
         rd_s0_reg <= mem[beat_index];
         rd_v0_reg <= beat_do && beat_read;
         rd_s1_reg <= rd_s0_reg;
         rd_v1_reg <= rd_v0_reg;
         data_valid_reg <= out_valid_next;
         data_bus_out_reg <= mode.cas3 ? rd_s1_reg : rd_s0_reg;
         for (int i = 0; i < LANES; i++) begin
            data_bus_oe_reg[8*i +: 8] <= {8{out_valid_next && !byte_lane_masks[i]}};
         end
      end
   end

   assign status = {state_reg == ST_WRITE, state_reg != ST_IDLE, row_open_reg};

   ahb_mode_regs u_regs (
      .ref_clk(ref_clk),
      .rst(rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hwdata(hwdata),
      .hready(hready),
      .load_mode(cmd == CMD_LOAD),
      .load_value(address_bits[MODE_WIDTH-1:0]),
      .status(status),
      .refresh_count(refresh_count_reg),
      .mode(mode),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp)
   );

   assign data_bus_out = data_bus_out_reg;
   assign data_bus_oe = data_bus_oe_reg;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence s_read_short;
      rd_acc && !mode.cas3 ##1 edge_ok;
   endsequence

   sequence s_read_long;
      rd_acc && mode.cas3 ##1 edge_ok ##1 edge_ok;
   endsequence

   sequence s_burst_four;
      rd_acc && mode.len_code == LEN_CODE_4 ##1 (edge_ok && cmd == CMD_NOP) [*3];
   endsequence

   property p_read_short;
      s_read_short |=> data_valid_reg;
   endproperty
   a_read_short: assert property (p_read_short)
      else $error("read data missing at latency two");

   property p_read_long;
      s_read_long |=> data_valid_reg;
   endproperty
   a_read_long: assert property (p_read_long)
      else $error("read data missing at latency three");

   property p_burst_four;
      s_burst_four |=> state_reg == ST_IDLE;
   endproperty
   a_burst_four: assert property (p_burst_four)
      else $error("four beat burst did not end");

   property p_activate;
      cmd == CMD_ACT |=> row_open_reg[$past(bank_select_bits)];
   endproperty
   a_activate: assert property (p_activate)
      else $error("activate left bank closed");

   property p_close_all;
      cmd == CMD_PRE && precharge_scope_bit |=> row_open_reg == 4'h0;
   endproperty
   a_close_all: assert property (p_close_all)
      else $error("precharge all left a row open");

   property p_deselect;
      cmd_pins.cs_n && state_reg == ST_IDLE |=> $stable(row_open_reg) && state_reg == ST_IDLE;
   endproperty
   a_deselect: assert property (p_deselect)
      else $error("deselected device changed state");

   property p_suspend;
      !edge_ok |=> $stable(state_reg) && $stable(burst_beat_reg) && $stable(data_bus_out_reg);
   endproperty
   a_suspend: assert property (p_suspend)
      else $error("voided edge changed state");

   property p_stop;
      cmd == CMD_STOP |=> state_reg == ST_IDLE;
   endproperty
   a_stop: assert property (p_stop)
      else $error("burst stop did not end burst");

   property p_single_write;
      wr_acc && mode.single_write |=> state_reg == ST_IDLE;
   endproperty
   a_single_write: assert property (p_single_write)
      else $error("single write mode kept bursting");

   property p_auto_close;
      go_on && burst_last && burst_auto_reg |=> !row_open_reg[$past(burst_bank_reg)];
   endproperty
   a_auto_close: assert property (p_auto_close)
      else $error("auto precharge left row open");

   property p_lane_mask;
      edge_ok && byte_lane_masks[0] |=> data_bus_oe_reg[7:0] == 8'h00;
   endproperty
   a_lane_mask: assert property (p_lane_mask)
      else $error("masked lane still driven");

   property p_random_col;
      go_new |=> burst_start_reg == $past(column_address_bits);
   endproperty
   a_random_col: assert property (p_random_col)
      else $error("new column not taken");

   property p_other_bank;
      state_reg != ST_IDLE && edge_ok && cmd == CMD_PRE && !precharge_scope_bit &&
         bank_select_bits != burst_bank_reg |-> beat_do;
   endproperty
   a_other_bank: assert property (p_other_bank)
      else $error("precharge of other bank cut burst");
endmodule : sdram_core

// ---- test/ctrl_model.sv ----
// ctrl_model: memory controller model driving the command and data pins
module ctrl_model
   import sdram_pkg::*;
(
   input wire logic ref_clk,
   output logic cke,
   output cmd_pins_t cmd_pins,
   output logic [1:0] bank_select_bits,
   output logic [10:0] address_bits,
   output logic [3:0] byte_lane_masks,
   output logic [31:0] data_bus_in,
   input wire logic [31:0] data_bus_out,
   input wire logic [31:0] data_bus_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cke = 1'b1;
      cmd_pins = 4'hF;
      bank_select_bits = 2'h0;
      address_bits = 11'h000;
      byte_lane_masks = 4'h0;
      data_bus_in = 32'h0000_0000;
   end

   // one command at the next edge; code is ras_n, cas_n, we_n
   task automatic send(input logic [2:0] code, input logic [1:0] bank, input logic [10:0] addr);
      @(posedge ref_clk);
      cmd_pins <= {1'b0, code};
      bank_select_bits <= bank;
      address_bits <= addr;
      @(posedge ref_clk);
      cmd_pins <= 4'hF;
   endtask : send

   // deselected command, then the same command on a voided edge
   task automatic void_cmd(input logic [2:0] code, input logic [1:0] bank, input logic [10:0] addr);
      @(posedge ref_clk);
      cmd_pins <= {1'b1, code};
      bank_select_bits <= bank;
      address_bits <= addr;
      cke <= 1'b0;
      @(posedge ref_clk);
      cke <= 1'b1;
      cmd_pins <= {1'b0, code};
      @(posedge ref_clk);
      cmd_pins <= 4'hF;
   endtask : void_cmd

   task automatic write_burst(input logic [1:0] bank, input logic [10:0] addr, input logic [3:0] m,
                              input int n, input logic [31:0] d [4]);
      @(posedge ref_clk);
      cmd_pins <= 4'h4;
      bank_select_bits <= bank;
      address_bits <= addr;
      byte_lane_masks <= m;
      data_bus_in <= d[0];
      for (int k = 1; k < n; k++) begin
         @(posedge ref_clk);
         cmd_pins <= 4'hF;
         data_bus_in <= d[k];
      end
      @(posedge ref_clk);
      cmd_pins <= 4'hF;
      byte_lane_masks <= 4'h0;
      data_bus_in <= ~d[n - 1]; // released bus shows no stale word
   endtask : write_burst

   task automatic read_burst(input logic [1:0] bank, input logic [10:0] addr, input logic [3:0] m,
                             input int lat, input int n, output logic [31:0] q [8], output logic [31:0] e [8]);
      byte_lane_masks <= m;
      send(3'h5, bank, addr);
      repeat (lat - 1) @(posedge ref_clk);
      for (int k = 0; k < n; k++) begin
         if (k > 0) @(posedge ref_clk);
         #1;
         q[k] = data_bus_out;
         e[k] = data_bus_oe;
      end
      byte_lane_masks <= 4'h0;
   endtask : read_burst
endmodule : ctrl_model

// ---- test/testbench.sv ----
// testbench: directed scenarios for the dram array and its register bus
module testbench
   import sdram_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic cke;
   cmd_pins_t cmd_pins;
   logic [1:0] bank_select_bits;
   logic [10:0] address_bits;
   logic [3:0] byte_lane_masks;
   logic [31:0] data_bus_in;
   logic [31:0] data_bus_out;
   logic [31:0] data_bus_oe;
   int n_fail = 0;
   int num_checks = 0;
   logic [31:0] r;
   logic [31:0] q [8];
   logic [31:0] e [8];
   logic [31:0] a [4] = '{32'hA1A1_0001, 32'hB2B2_0002, 32'hC3C3_0003, 32'hD4D4_0004};
   logic [31:0] b [4] = '{32'h1E2D_3C4B, 32'h5A69_7887, 32'h0F0F_F0F0, 32'h9966_6699};

   always #10 ref_clk = ~ref_clk;

   sdram_core sdram_core_inst (
      .ref_clk(ref_clk),
      .rst(rst),
      .cke(cke),
      .cmd_pins(cmd_pins),
      .bank_select_bits(bank_select_bits),
      .address_bits(address_bits),
      .byte_lane_masks(byte_lane_masks),
      .data_bus_in(data_bus_in),
      .data_bus_out(data_bus_out),
      .data_bus_oe(data_bus_oe),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(3'h2),
      .hwdata(hwdata),
      .hready(hreadyout),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp)
   );

   ctrl_model ctrl_model_inst (
      .ref_clk(ref_clk),
      .cke(cke),
      .cmd_pins(cmd_pins),
      .bank_select_bits(bank_select_bits),
      .address_bits(address_bits),
      .byte_lane_masks(byte_lane_masks),
      .data_bus_in(data_bus_in),
      .data_bus_out(data_bus_out),
      .data_bus_oe(data_bus_oe)
   );

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // returns at the rising edge where hready is sampled high
   task automatic wait_ready();
      int t;
      t = 0;
      @(negedge ref_clk);
      while (hreadyout !== 1'b1) begin
         t++;
         if (t > 50) begin
            n_fail++;
            end_sim();
         end
         @(negedge ref_clk);
      end
      @(posedge ref_clk);
   endtask : wait_ready

   task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wdat, output logic [31:0] rdat);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= addr;
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wdat;
      wait_ready();
      rdat = hrdata;
      check("hresp", {31'h0, hresp}, 32'h0);
   endtask : ahb

   task automatic t_regs();
      ahb(1'b0, 32'h0, 32'h0, r);
      check("mode reset", r, 32'h0000_0002);
      ahb(1'b0, 32'h4, 32'h0, r);
      check("status reset", r, 32'h0);
      ahb(1'b1, 32'h8, 32'hFFFF_FFFF, r);
      ctrl_model_inst.send(3'h1, 2'h0, 11'h000);
      ctrl_model_inst.send(3'h1, 2'h0, 11'h000);
      ahb(1'b0, 32'h8, 32'h0, r);
      check("refresh count", r, 32'h0000_0002);
      ahb(1'b0, 32'hC, 32'h0, r);
      check("unmapped", r, 32'h0);
      ahb(1'b1, 32'h0, 32'hFFFF_FFFF, r);
      ahb(1'b0, 32'h0, 32'h0, r);
      check("mode width", r, 32'h0000_003F);
      ctrl_model_inst.send(3'h0, 2'h0, 11'h002);
      ahb(1'b0, 32'h0, 32'h0, r);
      check("mode load", r, 32'h0000_0002);
      $display("done regs");
   endtask : t_regs

   task automatic t_burst();
      ctrl_model_inst.send(3'h3, 2'h3, 11'h7FF);
      ctrl_model_inst.write_burst(2'h3, 11'h0FE, 4'h0, 4, a);
      ctrl_model_inst.read_burst(2'h3, 11'h0FC, 4'h0, 2, 4, q, e);
      for (int k = 0; k < 4; k++) begin
         check("seq word", q[k], a[(k + 2) % 4]);
         check("seq enable", e[k], 32'hFFFF_FFFF);
      end
      ahb(1'b0, 32'h4, 32'h0, r);
      check("open banks", r, 32'h0000_0008);
      ahb(1'b1, 32'h0, 32'h0000_001A, r);
      ctrl_model_inst.read_burst(2'h3, 11'h0FD, 4'h1, 3, 4, q, e);
      for (int k = 0; k < 4; k++) begin
         check("ilv word", q[k] & 32'hFFFF_FF00, a[3 - k] & 32'hFFFF_FF00);
         check("ilv enable", e[k], 32'hFFFF_FF00);
      end
      ahb(1'b1, 32'h0, 32'h0000_0022, r);
      ctrl_model_inst.write_burst(2'h3, 11'h0FC, 4'hE, 1, b);
      ahb(1'b1, 32'h0, 32'h0000_0002, r);
      ctrl_model_inst.read_burst(2'h3, 11'h4FC, 4'h0, 2, 4, q, e);
      check("masked write", q[0], {a[2][31:8], b[0][7:0]});
      check("single write", q[1], a[3]);
      ahb(1'b0, 32'h4, 32'h0, r);
      check("auto close", r, 32'h0);
      ctrl_model_inst.read_burst(2'h3, 11'h0FC, 4'h0, 2, 1, q, e);
      check("closed bank", e[0], 32'h0);
      $display("done burst");
   endtask : t_burst

   task automatic t_stop();
      ctrl_model_inst.send(3'h3, 2'h0, 11'h001);
      for (int v = 0; v < 2; v++) begin
         ctrl_model_inst.write_burst(2'h0, 11'h000, 4'h0, 4, a);
         ctrl_model_inst.write_burst(2'h0, 11'h000, 4'h0, 2, b);
         ctrl_model_inst.send(v ? 3'h2 : 3'h6, 2'h2, 11'h000);
         ctrl_model_inst.read_burst(2'h0, 11'h000, 4'h0, 2, 4, q, e);
         check("cut first", q[0], b[0]);
         check("cut third", q[2], ~b[1]);
         check("cut tail", q[3], v ? ~b[1] : a[3]);
      end
      $display("done stop");
   endtask : t_stop

   task automatic t_suspend();
      ctrl_model_inst.void_cmd(3'h3, 2'h1, 11'h000);
      ahb(1'b0, 32'h4, 32'h0, r);
      check("ignored activate", r, 32'h0000_0001);
      ctrl_model_inst.send(3'h3, 2'h1, 11'h000);
      ahb(1'b0, 32'h4, 32'h0, r);
      check("valid activate", r, 32'h0000_0003);
      ahb(1'b1, 32'h0, 32'h0000_0003, r);
      ctrl_model_inst.write_burst(2'h1, 11'h005, 4'h0, 4, b);
      repeat (4) @(posedge ref_clk);
      ctrl_model_inst.read_burst(2'h1, 11'h005, 4'h0, 2, 8, q, e);
      for (int k = 0; k < 8; k++) begin
         check("eight word", q[k], (k < 4) ? b[k % 4] : ~b[3]);
         check("eight enable", e[k], 32'hFFFF_FFFF);
      end
      ctrl_model_inst.send(3'h2, 2'h0, 11'h400);
      ahb(1'b0, 32'h4, 32'h0, r);
      check("close all", r, 32'h0);
      $display("done suspend");
   endtask : t_suspend

   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      t_regs();
      t_burst();
      t_stop();
      t_suspend();
      end_sim();
   end
endmodule : testbench
